// ---- design/dlt_defines.svh ----
// Constants for the level-two debug trigger combiner.
// Assumes inclusion by bare name from design files; APB byte addresses.
// Notes on behaviour
// - Bit 15 is ignored for trigger formation
// - Bit 31 selects the condition combination
// - Bit31=0: trigger is AND of all three
// - Bit31=1: trigger is PC or (address and data)
// - Code 00 trace, 01 halt, 10 interrupt
`ifndef DLT_DEFINES_SVH
`define DLT_DEFINES_SVH

`define DLT_TRIG_DEF_OFFSET   12'h000
`define DLT_STATUS_OFFSET     12'h004
`define DLT_TRIG_DEF_RESET    32'h0000_0000
`define DLT_COMB_SEL_BIT      31
`define DLT_RESP_HI_BIT       31
`define DLT_RESP_LO_BIT       30
`define DLT_OLD_LOGIC_BIT     15
`define DLT_STAT_TRIG_BIT     0
`define DLT_STAT_RSVD_BIT     1

`endif

// ---- design/dlt_pkg.sv ----
// Types for the level-two debug trigger combiner.
// Assumes no surroundings beyond the design file that uses it.
package dlt_pkg;
  typedef enum logic [1:0] {
    DLT_RESP_TRACE    = 2'b00,
    DLT_RESP_HALT     = 2'b01,
    DLT_RESP_DBG_INT  = 2'b10,
    DLT_RESP_RESERVED = 2'b11
  } dlt_resp_t;
endpackage

// ---- design/dlt_trigger.sv ----
// Level-two trigger combiner with its definition register on APB.
// Assumes condition inputs come from core logic on ref_clk.
// Assumes an APB master that holds each request until pready is sampled high.
//
// The APB interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "dlt_defines.svh"

module dlt_trigger (
  input  wire logic        ref_clk,
  input  wire logic        reset_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        pc_match_cond,
  input  wire logic        addr_range_cond,
  input  wire logic        data_match_cond,
  output logic             trace_data_output,
  output logic             halt_req,
  output logic             debug_int_req
);
  // Stored state
  logic [31:0]        trigger_definition_reg;
  logic               trig_seen;
  logic               reserved_seen;

  // Bus decode
  logic               acc;
  logic               setup_rd;
  logic               hit_def;
  logic               hit_stat;
  logic               hit_any;
  logic               wr_def;
  logic               wr_stat;
  logic               clr_trig;
  logic               clr_rsvd;

  // Trigger formation
  logic               comb_or;
  dlt_pkg::dlt_resp_t resp;
  logic               and_form;
  logic               or_form;
  logic               level2;
  logic               is_rsvd;

  // Next values
  logic [31:0]        next_trigger_definition_reg;
  logic               next_trig_seen;
  logic               next_reserved_seen;
  logic [31:0]        stat_word;
  logic [31:0]        next_prdata;

  // Access phase of a transfer
  function automatic logic dlt_access(
    input logic sel,
    input logic en
  );
    logic result;
    result = sel & en;
    return result;
  endfunction

  // Setup cycle of a read, where read data is loaded
  function automatic logic dlt_setup_read(
    input logic sel,
    input logic en,
    input logic wr
  );
    logic result;
    result = sel & ~en & ~wr;
    return result;
  endfunction

  // Address match against one register offset
  function automatic logic dlt_hit(
    input logic [11:0] addr,
    input logic [11:0] offset
  );
    logic match;
    match = (addr == offset);
    return match;
  endfunction

  // Error only for an access outside the register map
  function automatic logic dlt_error(
    input logic in_access,
    input logic mapped
  );
    logic result;
    result = in_access & ~mapped;
    return result;
  endfunction

  // Response code held in the top two bits of the definition word
  function automatic dlt_pkg::dlt_resp_t dlt_resp_of(
    input logic [31:0] word
  );
    logic [1:0] code;
    code = word[`DLT_RESP_HI_BIT:`DLT_RESP_LO_BIT];
    return dlt_pkg::dlt_resp_t'(code);
  endfunction

  // All three conditions together
  function automatic logic dlt_and3(
    input logic pc,
    input logic span,
    input logic data
  );
    logic result;
    result = pc & span & data;
    return result;
  endfunction

  // Program counter alone, or address range with data
  function automatic logic dlt_or_pair(
    input logic pc,
    input logic span,
    input logic data
  );
    logic pair;
    logic result;
    pair   = span & data;
    result = pc | pair;
    return result;
  endfunction

  // Pick the combination named by the select bit
  function automatic logic dlt_combine(
    input logic sel_or,
    input logic and_val,
    input logic or_val
  );
    logic result;
    case (sel_or)
      1'b0:    result = and_val;
      1'b1:    result = or_val;
      default: result = and_val;
    endcase
    return result;
  endfunction

  // Pass the trigger to one response output only for its own code
  function automatic logic dlt_gate(
    input logic               level,
    input dlt_pkg::dlt_resp_t code,
    input dlt_pkg::dlt_resp_t want
  );
    logic result;
    result = level & (code == want);
    return result;
  endfunction

  // Reserved code: the trigger is formed but drives no response
  function automatic logic dlt_is_reserved(
    input dlt_pkg::dlt_resp_t code
  );
    logic result;
    case (code)
      dlt_pkg::DLT_RESP_RESERVED: result = 1'b1;
      default:                    result = 1'b0;
    endcase
    return result;
  endfunction

  // Sticky flag: an event in the cycle of a clear still sets it
  function automatic logic dlt_sticky(
    input logic cur,
    input logic set,
    input logic clr
  );
    logic result;
    result = set | (cur & ~clr);
    return result;
  endfunction

  // Whole-word update of the definition register
  function automatic logic [31:0] dlt_next_word(
    input logic        wr,
    input logic [31:0] wdata,
    input logic [31:0] cur
  );
    logic [31:0] word;
    case (wr)
      1'b1:    word = wdata;
      default: word = cur;
    endcase
    return word;
  endfunction

  // Status word layout
  function automatic logic [31:0] dlt_status_word(
    input logic rsvd,
    input logic trig
  );
    logic [31:0] word;
    word                     = 32'h0000_0000;
    word[`DLT_STAT_TRIG_BIT] = trig;
    word[`DLT_STAT_RSVD_BIT] = rsvd;
    return word;
  endfunction

  // Read data for a setup cycle; unmapped offsets read as zero
  function automatic logic [31:0] dlt_read_word(
    input logic        sel_def,
    input logic        sel_stat,
    input logic [31:0] def_word,
    input logic [31:0] stat_in
  );
    logic [31:0] word;
    case ({sel_def, sel_stat})
      2'b10:   word = def_word;
      2'b01:   word = stat_in;
      default: word = 32'h0000_0000;
    endcase
    return word;
  endfunction

  // Read data is loaded only in a read setup cycle and held otherwise
  function automatic logic [31:0] dlt_next_read(
    input logic        setup,
    input logic [31:0] word,
    input logic [31:0] held
  );
    logic [31:0] result;
    case (setup)
      1'b1:    result = word;
      default: result = held;
    endcase
    return result;
  endfunction

  // APB decode
  assign acc      = dlt_access(psel, penable);
  assign setup_rd = dlt_setup_read(psel, penable, pwrite);
  assign hit_def  = dlt_hit(paddr, `DLT_TRIG_DEF_OFFSET);
  assign hit_stat = dlt_hit(paddr, `DLT_STATUS_OFFSET);
  assign hit_any  = hit_def | hit_stat;
  assign wr_def   = acc & pwrite & hit_def;
  assign wr_stat  = acc & pwrite & hit_stat;
  assign clr_trig = wr_stat & pwdata[`DLT_STAT_TRIG_BIT];
  assign clr_rsvd = wr_stat & pwdata[`DLT_STAT_RSVD_BIT];

  // Zero wait states
  assign pready  = 1'b1;
  assign pslverr = dlt_error(acc, hit_any);

  // Bit 15 is stored but never enters the trigger equation
  assign comb_or  = trigger_definition_reg[`DLT_COMB_SEL_BIT];
  assign resp     = dlt_resp_of(trigger_definition_reg);
  assign and_form = dlt_and3(pc_match_cond, addr_range_cond, data_match_cond);
  assign or_form  = dlt_or_pair(pc_match_cond, addr_range_cond, data_match_cond);
  assign level2   = dlt_combine(comb_or, and_form, or_form);
  assign is_rsvd  = dlt_is_reserved(resp);

  // Response outputs follow the trigger in the same cycle
  assign trace_data_output = dlt_gate(level2, resp, dlt_pkg::DLT_RESP_TRACE);
  assign halt_req          = dlt_gate(level2, resp, dlt_pkg::DLT_RESP_HALT);
  assign debug_int_req     = dlt_gate(level2, resp, dlt_pkg::DLT_RESP_DBG_INT);

  // Next values
  assign next_trigger_definition_reg = dlt_next_word(wr_def, pwdata, trigger_definition_reg);
  assign next_trig_seen              = dlt_sticky(trig_seen, level2, clr_trig);
  assign next_reserved_seen          = dlt_sticky(reserved_seen, is_rsvd, clr_rsvd);
  assign stat_word                   = dlt_status_word(reserved_seen, trig_seen);
  assign next_prdata                 = dlt_next_read(setup_rd,
    dlt_read_word(hit_def, hit_stat, trigger_definition_reg, stat_word),
    prdata);

  // Definition register
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      trigger_definition_reg <= `DLT_TRIG_DEF_RESET;
    end else begin
      trigger_definition_reg <= next_trigger_definition_reg;
    end
  end

  // Trigger seen, write 1 clears
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      trig_seen <= 1'b0;
    end else begin
      trig_seen <= next_trig_seen;
    end
  end

  // Reserved code in use, write 1 clears
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      reserved_seen <= 1'b0;
    end else begin
      reserved_seen <= next_reserved_seen;
    end
  end

  // Read data register
  always_ff @(posedge ref_clk) begin
    if (!reset_n) begin
      prdata <= 32'h0000_0000;
    end else begin
      prdata <= next_prdata;
    end
  end

endmodule // dlt_trigger

// ---- dv/dlt_core_model.sv ----
// Core model: condition levels follow want one cycle later.
// Assumes want is driven by the bench just after rising ref_clk edges.
`timescale 1ns/1ps
module dlt_core_model (
  input  wire logic       ref_clk,
  input  wire logic [2:0] want,
  output logic      [2:0] cond
);
  always_ff @(posedge ref_clk) begin
    cond <= want;
  end
endmodule // dlt_core_model

// ---- dv/dlt_trigger_properties.sv ----
// Trigger checker: response outputs against conditions and the programmed code.
// Assumes a bind into dlt_trigger; it sees only that module's ports.
`timescale 1ns/1ps
module dlt_trigger_properties (
  input wire logic        ref_clk,
  input wire logic        reset_n,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pc_match_cond,
  input wire logic        addr_range_cond,
  input wire logic        data_match_cond,
  input wire logic        trace_data_output,
  input wire logic        halt_req,
  input wire logic        debug_int_req
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!reset_n);
  wire a3 = pc_match_cond & addr_range_cond & data_match_cond;
  wire o3 = pc_match_cond | (addr_range_cond & data_match_cond);
  // Definition write carrying a given response code
  sequence set_m(c);
    psel & penable & pwrite & (paddr == 12'h000) & (pwdata[31:30] == c);
  endsequence
  and_resp_a: assert property (trace_data_output | halt_req |-> a3) else $error("and");
  or_resp_a: assert property (debug_int_req |-> o3) else $error("or");
  int_mode_a: assert property (set_m(2) |=> debug_int_req == o3) else $error("int");
  trace_mode_a: assert property (set_m(0) |=> trace_data_output == a3) else $error("tr");
  halt_mode_a: assert property (set_m(1) |=> halt_req == a3) else $error("halt");
  one_resp_a: assert property ($onehot0({trace_data_output, halt_req, debug_int_req}))
    else $error("one");
  hold_resp_a: assert property ($stable(a3) && $past(reset_n & !(psel & pwrite))
    |-> $stable(trace_data_output)) else $error("hold");
endmodule // dlt_trigger_properties
bind dlt_trigger dlt_trigger_properties u_props (.*);

// ---- dv/tb_debug_level2_trigger_logic.sv ----
// Bench: APB mode writes, random conditions, queued output checks.
// Assumes the core model turns want into condition levels one cycle later.
`timescale 1ns/1ps
module tb_debug_level2_trigger_logic;
  logic ref_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, t, h, d;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, r;
  logic [2:0] want = 0, p = 0, c, q[$];
  logic [1:0] m = 0;
  logic fired = 0;
  integer seed = 9, bad_count = 0, check_count = 0, n, i;
  dlt_core_model core (.ref_clk, .want, .cond(c));
  dlt_trigger dut (.ref_clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .pc_match_cond(c[2]), .addr_range_cond(c[1]), .data_match_cond(c[0]),
    .trace_data_output(t), .halt_req(h), .debug_int_req(d));
  initial forever #5 ref_clk = ~ref_clk;
  task chk(input logic [31:0] g, e);
    check_count++;
    if (g !== e) begin bad_count++; $display("FAIL %0t got %h", $time, g); end
  endtask
  task close_out;
    $display("checks %0d bad %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] wd, ed, input logic ee);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, wd};
    @(posedge ref_clk) penable <= 1;
    n = 0;
    do @(posedge ref_clk) n++; while (pready !== 1 && n < 99);
    if (pready !== 1) begin bad_count++; $display("FAIL %0t no ready", $time); close_out; end
    if (!w) chk(prdata, ed);
    chk(pslverr, ee);
    {psel, penable} <= 0;
    @(posedge ref_clk);
  endtask
  function logic [2:0] ex(input logic [2:0] v);
    logic x;
    x = m[1] ? v[2] | v[1] & v[0] : &v;
    return {m == 0 && x, m == 1 && x, m == 2 && x};
  endfunction
  always @(negedge ref_clk) if (q.size()) chk({t, h, d}, q.pop_front());
  initial begin
    repeat (12) @(posedge ref_clk);
    reset_n <= 1;
    @(posedge ref_clk);
    apb(0, 0, 0, 0, 0);
    apb(0, 12'h008, 0, 0, 1);
    for (i = 0; i < 8; i++) begin
      m = 2'(i % 3);
      r = {m, 30'($random(seed))};
      r[15] = i[2];
      fired = 0;
      apb(1, 0, r, 0, 0);
      apb(0, 0, 0, r, 0);
      for (n = 0; n < 24; n++) begin
        @(posedge ref_clk);
        q.push_back(ex(p));
        fired = fired | (|ex(p));
        p = n < 23 ? 3'($random(seed)) : 3'h0;
        want <= p;
      end
      repeat (2) @(posedge ref_clk);
      apb(0, 12'h004, 0, {31'h0, fired}, 0);
      apb(1, 12'h004, 32'h3, 0, 0);
      apb(0, 12'h004, 0, 0, 0);
    end
    close_out;
  end
endmodule // tb_debug_level2_trigger_logic
